// *** scc_spi_control.sv ***
// How it works
// [R1] Receive or fault flag raises enabled interrupt
// [R2] Disable aborts transfer, clears buffers, flags; code keeps buffer contents and fault flag
// [R3] Transmit-empty flag raises enabled interrupt
// [R4] Role bit: zero slave, one master
// [R5] Polarity sets serial clock idle level
// [R6] Phase picks first edge mid or start
// [R7] Bit-order bit selects shift direction
// [R8] Master without fault enable frees select
// [R9] Master fault enable: fault input or select
// [R10] Slave: select pin is active-low input
// [R11] Drive enable steers shared pin direction
// [R12] Single-wire uses master or slave pin
// [R13] Wait-stop bit freezes clocks in wait
// [R14] Unused option bits read zero
// [R15] Software never disables with phase change
// [R16] Receive-full set at end, cleared read pair
// [R17] Transmit-empty set when buffer has room
// [R18] Control registers reset to zero
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scc_spi_control (
  // Clock, reset, enable, wait
  input  wire logic       CLK_IN,
  input  wire logic       RESET_IN,
  input  wire logic       CLK_EN_IN,
  input  wire logic       WAIT_MODE_IN,
  // APB slave
  input  wire logic       PSEL_IN,
  input  wire logic       PENABLE_IN,
  input  wire logic       PWRITE_IN,
  input  wire logic [7:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]     PRDATA_OUT,
  output logic            PREADY_OUT,
  output logic            PSLVERR_OUT,
  // Interrupt
  output logic            IRQ_OUT,
  // Serial clock pin
  input  wire logic       SCK_IN,
  output logic            SCK_OUT,
  output logic            SCK_OE_OUT,
  // Master-out pin, shared in master single-wire
  input  wire logic       MOSI_IN,
  output logic            MOSI_OUT,
  output logic            MOSI_OE_OUT,
  // Master-in pin, shared in slave single-wire
  input  wire logic       MISO_IN,
  output logic            MISO_OUT,
  output logic            MISO_OE_OUT,
  // Slave select pin
  input  wire logic       SEL_N_IN,
  output logic            SEL_N_OUT,
  output logic            SEL_OE_OUT
);
  import scc_pkg::*;

  typedef enum logic [1:0] {IDLE, SHIFT_LEAD, SHIFT_TRAIL} scc_state_type;

  logic [7:0] spi_main_control;
  logic [7:0] spi_option_control;
  logic       rx_full_flag;
  logic       tx_empty_flag;
  logic       fault_flag;
  logic       status_seen_rx;
  logic       status_seen_tx;
  logic [7:0] tx_buffer;
  logic [7:0] rx_buffer;
  logic [7:0] shifter;
  logic [3:0] bit_count;
  logic [7:0] div_count;
  logic       sample_bit;
  logic       sck_level;
  scc_state_type state;
  logic [2:0] sck_sync;
  logic [1:0] mosi_sync;
  logic [1:0] miso_sync;
  logic [2:0] sel_sync;

  // Control field decode
  wire rx_fault_irq_enable      = spi_main_control[RX_IRQ_EN_BIT];
  wire module_enable            = spi_main_control[ENABLE_BIT];
  wire tx_empty_irq_enable      = spi_main_control[TX_IRQ_EN_BIT];
  wire master_select            = spi_main_control[MASTER_BIT];
  wire clock_polarity           = spi_main_control[POLARITY_BIT];
  wire clock_phase              = spi_main_control[PHASE_BIT];
  wire select_output_enable     = spi_main_control[SEL_OUT_EN_BIT];
  wire low_bit_first            = spi_main_control[LOW_FIRST_BIT];
  wire fault_detect_enable      = spi_option_control[FAULT_EN_BIT];
  wire single_wire_drive_enable = spi_option_control[WIRE_DRIVE_BIT];
  wire wait_clock_stop          = spi_option_control[WAIT_STOP_BIT];
  wire single_wire_select       = spi_option_control[SINGLE_WIRE_BIT];

  // Frozen by the enable input or, when asked, by processor wait
  // [R13] wait clock stop
  wire run = CLK_EN_IN & ~(wait_clock_stop & WAIT_MODE_IN);

  // APB decode; zero wait states, so reads and writes land on access cycle
  wire access    = PSEL_IN & PENABLE_IN;
  wire wr        = access & PWRITE_IN;
  wire rd        = access & ~PWRITE_IN;
  wire hit_main  = PADDR_IN == MAIN_CONTROL_ADDR;
  wire hit_opt   = PADDR_IN == OPTION_CONTROL_ADDR;
  wire hit_stat  = PADDR_IN == STATUS_ADDR;
  wire hit_data  = PADDR_IN == DATA_ADDR;
  wire mapped    = hit_main | hit_opt | hit_stat | hit_data;
  wire wr_main   = wr & hit_main & run;
  wire wr_opt    = wr & hit_opt & run;
  wire rd_stat   = rd & hit_stat & run;
  wire rd_data   = rd & hit_data & run;
  // Data write only accepted after status was seen with room
  wire wr_data   = wr & hit_data & run & status_seen_tx & tx_empty_flag;
  wire [7:0] status_value = {rx_full_flag, 1'b0, tx_empty_flag, fault_flag, 4'h0};

  // Pin roles
  // [R10] slave select input
  wire sel_is_input  = ~master_select;
  // [R8] master frees select
  // [R9] fault or select out
  wire sel_is_fault  = master_select & fault_detect_enable & ~select_output_enable;
  wire sel_is_output = master_select & fault_detect_enable & select_output_enable;
  wire slave_chosen  = module_enable & sel_is_input & ~sel_sync[1];
  // [R12] shared data pin
  wire shared_mosi   = single_wire_select & master_select;
  wire shared_miso   = single_wire_select & ~master_select;
  // [R11] shared pin direction
  wire drive_data    = ~single_wire_select | single_wire_drive_enable;

  // Incoming serial bit from whichever pin faces this role
  wire in_bit = master_select ? (shared_mosi ? mosi_sync[1] : miso_sync[1])
                              : (shared_miso ? miso_sync[1] : mosi_sync[1]);
  // [R7] shift direction
  wire out_bit = low_bit_first ? shifter[0] : shifter[7];
  wire [7:0] shifted = low_bit_first ? {sample_bit, shifter[7:1]}
                                     : {shifter[6:0], sample_bit};
  // Same shift fed straight from the pin; phase one samples its last bit
  // on the closing edge, too late for the held sample to be ready
  wire [7:0] shifted_live = low_bit_first ? {in_bit, shifter[7:1]}
                                          : {shifter[6:0], in_bit};

  // Slave clock edges, polarity removed
  wire sck_rise = sck_sync[1] & ~sck_sync[2];
  wire sck_fall = ~sck_sync[1] & sck_sync[2];
  // [R5] polarity inverts
  wire lead_edge  = clock_polarity ? sck_fall : sck_rise;
  wire trail_edge = clock_polarity ? sck_rise : sck_fall;
  wire fault_now  = module_enable & sel_is_fault & ~sel_sync[1] & ~sel_sync[2];
  wire tick       = div_count == 8'h00;

  // Input synchronisers; first stage feeds only the second
  // The third stage of clock and select exists only for edge and
  // hold detection, so a pin edge costs about three system clocks
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      sck_sync  <= 3'h0;
      mosi_sync <= 2'h0;
      miso_sync <= 2'h0;
      sel_sync  <= 3'h7;
    end else if (run) begin
      sck_sync  <= {sck_sync[1:0], SCK_IN};
      mosi_sync <= {mosi_sync[0], MOSI_IN};
      miso_sync <= {miso_sync[0], MISO_IN};
      sel_sync  <= {sel_sync[1:0], SEL_N_IN};
    end
  end

  // Control registers
  // [R18] reset zero
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      spi_main_control   <= MAIN_RESET;
      spi_option_control <= OPTION_RESET;
    end else begin
      if (wr_main) begin
        spi_main_control <= PWDATA_IN[7:0];
      end
      // [R14] unused bits zero
      if (wr_opt) begin
        spi_option_control <= PWDATA_IN[7:0] & OPTION_IMPL_MASK;
      end
    end
  end

  // Status flags, transmit buffer and the shift engine
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rx_full_flag   <= 1'b0;
      tx_empty_flag  <= 1'b1;
      fault_flag     <= 1'b0;
      status_seen_rx <= 1'b0;
      status_seen_tx <= 1'b0;
      tx_buffer      <= 8'h00;
      rx_buffer      <= 8'h00;
      shifter        <= 8'h00;
      bit_count      <= 4'h0;
      div_count      <= 8'h00;
      sample_bit     <= 1'b0;
      sck_level      <= 1'b0;
      state          <= IDLE;
    end else if (run) begin
      // Read of status arms the clearing sequences
      if (rd_stat) begin
        status_seen_rx <= rx_full_flag;
        status_seen_tx <= tx_empty_flag;
      end
      // [R16] read pair clears
      if (rd_data && status_seen_rx) begin
        rx_full_flag   <= 1'b0;
        status_seen_rx <= 1'b0;
      end
      if (wr_data) begin
        tx_buffer      <= PWDATA_IN[7:0];
        tx_empty_flag  <= 1'b0;
        status_seen_tx <= 1'b0;
      end
      // Fault stays until software sees it via status read
      if (rd_stat && fault_flag) begin
        fault_flag <= 1'b0;
      end
      if (fault_now) begin
        fault_flag <= 1'b1;
      end
      div_count <= tick ? HALF_BIT_CYCLES - 8'h01 : div_count - 8'h01;
      // Every bit is one leading and one trailing edge; the phase bit only
      // swaps which of the two samples the line and which moves data out
      unique case (state)
        IDLE: begin
          sck_level <= 1'b0;
          // [R17] load frees buffer
          // A master waits for queued data; a selected slave always shifts,
          // sending whatever the buffer holds, since its master owns timing
          if (!wr_data && (master_select ? !tx_empty_flag : slave_chosen)) begin
            shifter       <= tx_buffer;
            tx_empty_flag <= 1'b1;
            bit_count     <= 4'h0;
            div_count     <= HALF_BIT_CYCLES - 8'h01;
            state         <= SHIFT_LEAD;
          end
        end
        // Leading edge: phase zero samples, phase one moves next bit out
        SHIFT_LEAD: begin
          if (master_select ? tick : lead_edge) begin
            sck_level <= 1'b1;
            state     <= SHIFT_TRAIL;
            // [R6] phase picks edges
            if (!clock_phase) begin
              sample_bit <= in_bit;
            end else if (bit_count != 4'h0) begin
              // First bit already stands on the pin since the load
              shifter <= shifted;
            end
          end
        end
        // Trailing edge: phase zero moves the bit out, phase one samples
        SHIFT_TRAIL: begin
          if (master_select ? tick : trail_edge) begin
            sck_level <= 1'b0;
            state     <= SHIFT_LEAD;
            bit_count <= bit_count + 4'h1;
            if (!clock_phase) begin
              shifter <= shifted;
            end else begin
              sample_bit <= in_bit;
            end
            if (bit_count == BITS_PER_FRAME - 4'h1) begin
              // [R16] frame done sets
              rx_full_flag <= 1'b1;
              rx_buffer    <= clock_phase ? shifted_live : shifted;
              state        <= IDLE;
            end
          end
        end
        default: state <= IDLE;
      endcase
      // A mode fault ends any frame; the role bit is left for software,
      // so a master keeps driving its clock idle until it is reconfigured
      if (fault_now) begin
        state     <= IDLE;
        sck_level <= 1'b0;
      end
      // A slave frame ends when its master lets go of the select pin;
      // without this a short frame would leave the engine mid-byte
      if (!master_select && sel_sync[1]) begin
        state     <= IDLE;
        sck_level <= 1'b0;
      end
      // [R2] disable aborts frame, clears receive flag, sets transmit-empty
      if (!module_enable) begin
        state          <= IDLE;
        rx_full_flag   <= 1'b0;
        tx_empty_flag  <= 1'b1;
        status_seen_rx <= 1'b0;
        sck_level      <= 1'b0;
        bit_count      <= 4'h0;
      end
    end
  end

  // Register read mux; the data address shows the last received byte,
  // the transmit buffer cannot be read back
  wire [7:0] read_byte = hit_main ? spi_main_control
                       : hit_opt  ? spi_option_control
                       : hit_stat ? status_value
                       : hit_data ? rx_buffer : 8'h00;

  // Read data is captured in the setup cycle, so it stands through the
  // access cycle even though the flag clears land at the access edge
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      PRDATA_OUT <= {24'h00_0000, read_byte};
    end
  end

  // Interrupt and APB answers
  // The slave never stalls, so a master sees no wait states at all
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access & ~mapped;
  // [R1] receive irq
  // [R3] transmit irq
  assign IRQ_OUT = (rx_fault_irq_enable & (rx_full_flag | fault_flag))
                 | (tx_empty_irq_enable & tx_empty_flag);

  // Pin drivers; disabled module leaves all pins to the port logic
  // [R5] idle level
  assign SCK_OUT     = sck_level ^ clock_polarity;
  // [R4] master drives clock
  assign SCK_OE_OUT  = module_enable & master_select;
  assign MOSI_OUT    = out_bit;
  assign MOSI_OE_OUT = module_enable & master_select & drive_data;
  assign MISO_OUT    = out_bit;
  assign MISO_OE_OUT = module_enable & ~master_select & slave_chosen & drive_data;
  // Select output low while a master frame runs
  assign SEL_N_OUT   = state == IDLE;
  assign SEL_OE_OUT  = module_enable & sel_is_output;
endmodule : scc_spi_control
`default_nettype wire

// *** scc_pkg.sv ***
package scc_pkg;
  // Register byte addresses
  localparam logic [7:0] MAIN_CONTROL_ADDR   = 8'h00;
  localparam logic [7:0] OPTION_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR         = 8'h08;
  localparam logic [7:0] DATA_ADDR           = 8'h0c;
  // Main control field positions
  localparam int RX_IRQ_EN_BIT   = 7;
  localparam int ENABLE_BIT      = 6;
  localparam int TX_IRQ_EN_BIT   = 5;
  localparam int MASTER_BIT      = 4;
  localparam int POLARITY_BIT    = 3;
  localparam int PHASE_BIT       = 2;
  localparam int SEL_OUT_EN_BIT  = 1;
  localparam int LOW_FIRST_BIT   = 0;
  // Option control field positions
  localparam int FAULT_EN_BIT    = 4;
  localparam int WIRE_DRIVE_BIT  = 3;
  localparam int WAIT_STOP_BIT   = 1;
  localparam int SINGLE_WIRE_BIT = 0;
  localparam logic [7:0] OPTION_IMPL_MASK = 8'h1b;
  // Status field positions
  localparam int RX_FULL_BIT     = 7;
  localparam int FAULT_BIT       = 4;
  localparam int TX_EMPTY_BIT    = 5;
  // Reset values
  localparam logic [7:0] MAIN_RESET   = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  // Bit clock divider: half period in system clocks
  localparam logic [7:0] HALF_BIT_CYCLES = 8'h04;
  localparam logic [3:0] BITS_PER_FRAME  = 4'h8;
endpackage : scc_pkg

// *** scc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module scc_checker (
  // Clock and control
  input wire logic        CLK_IN,
  input wire logic        RESET_IN,
  input wire logic        CLK_EN_IN,
  input wire logic        WAIT_MODE_IN,
  // Bus
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  // Pins
  input wire logic        IRQ_OUT,
  input wire logic        SCK_OUT,
  input wire logic        SCK_OE_OUT,
  input wire logic        MOSI_OE_OUT,
  input wire logic        MISO_OE_OUT,
  input wire logic        SEL_N_OUT,
  input wire logic        SEL_OE_OUT
);
  import scc_pkg::*;
  logic [7:0] mc;
  logic [7:0] oc;
  wire logic  wr  = PSEL_IN & PENABLE_IN & PWRITE_IN & CLK_EN_IN;
  wire logic  mst = mc[ENABLE_BIT] & mc[MASTER_BIT];
  // Shadow controls, so pin rules are judged from bus traffic alone
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      mc <= MAIN_RESET;
      oc <= OPTION_RESET;
    end else if (wr && PADDR_IN == MAIN_CONTROL_ADDR) begin
      mc <= PWDATA_IN[7:0];
    end else if (wr && PADDR_IN == OPTION_CONTROL_ADDR) begin
      oc <= PWDATA_IN[7:0] & OPTION_IMPL_MASK;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // Stable guard tolerates a registered pin decode
  property p_role;
    $stable({mc, oc}) |-> (mc[MASTER_BIT] ? !MISO_OE_OUT : !(SCK_OE_OUT | MOSI_OE_OUT | SEL_OE_OUT));
  endproperty
  a_role: assert property (p_role) else $error("pin role wrong");
  property p_idle;
    (mst && SEL_N_OUT && $stable(mc))[*3] |-> SCK_OUT == mc[POLARITY_BIT];
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle wrong");
  property p_sel_drive;
    $stable({mc, oc}) && mst && oc[FAULT_EN_BIT] && mc[SEL_OUT_EN_BIT] |-> SEL_OE_OUT;
  endproperty
  a_sel_drive: assert property (p_sel_drive) else $error("select not driven");
  property p_sel_free;
    $stable({mc, oc}) && mc[MASTER_BIT] && !oc[FAULT_EN_BIT] |-> !SEL_OE_OUT;
  endproperty
  a_sel_free: assert property (p_sel_free) else $error("select not free");
  property p_wire;
    $stable({mc, oc}) && mst && oc[SINGLE_WIRE_BIT] && !oc[WIRE_DRIVE_BIT] |-> !MOSI_OE_OUT;
  endproperty
  a_wire: assert property (p_wire) else $error("shared pin driven");
  property p_tx_irq;
    (!mc[ENABLE_BIT] && mc[TX_IRQ_EN_BIT])[*2] |-> IRQ_OUT;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("idle irq missing");
  property p_irq_off;
    $stable(mc) && !mc[RX_IRQ_EN_BIT] && !mc[TX_IRQ_EN_BIT] |-> !IRQ_OUT;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  property p_wait;
    WAIT_MODE_IN && $past(WAIT_MODE_IN) && $past(WAIT_MODE_IN, 2) && oc[WAIT_STOP_BIT]
      |-> $stable(SCK_OUT) && $stable(IRQ_OUT);
  endproperty
  a_wait: assert property (p_wait) else $error("ran in wait");
  cover property (SEL_OE_OUT && !SEL_N_OUT);
  cover property (IRQ_OUT && mc[RX_IRQ_EN_BIT]);
  cover property (WAIT_MODE_IN && oc[WAIT_STOP_BIT]);
endmodule : scc_checker
bind scc_spi_control scc_checker i_scc_checker (.*);
`default_nettype wire

// *** scc_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module scc_slave_model (
  // Serial side of a loop-back slave
  input  wire logic sel_n_in,
  input  wire logic mosi_in,
  output logic      miso_out
);
  logic last_bit = 1'b0;
  // Echo while selected; once released show the inverse, never a stale bit
  always @(sel_n_in or mosi_in) begin
    if (!sel_n_in) begin
      last_bit = mosi_in;
    end
  end
  assign miso_out = sel_n_in ? ~last_bit : mosi_in;
endmodule : scc_slave_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scc_pkg::*;
  localparam logic [7:0] SLV = 8'ha6;
  logic clk = 1'b0, rst = 1'b1, wt = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_o, sel_oe;
  logic part, tb_sck = 1'b0, tb_sel_n = 1'b1, tb_mosi = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  logic [7:0] tm [8] = '{8'h50, 8'h52, 8'h50, 8'h52, 8'h52, 8'h52, 8'h5a, 8'h42};
  logic [7:0] to [8] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h11, 8'h19, 8'h00, 8'h19};
  logic [4:0] te [8] = '{5'h0a, 5'h0a, 5'h0a, 5'h1a, 5'h12, 5'h1a, 5'h0b, 5'h00};
  // Pin levels; select idles high through its pull-up
  wire logic sck  = sck_oe ? sck_o : tb_sck;
  wire logic mosi = mosi_oe ? mosi_o : tb_mosi;
  wire logic miso = miso_oe ? miso_o : part;
  wire logic seln = sel_oe ? sel_o : tb_sel_n;
  always #2.5 clk = ~clk;
  scc_spi_control i_scc_spi_control (
    .CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(1'b1), .WAIT_MODE_IN(wt), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq),
    .SCK_IN(sck), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe), .MOSI_IN(mosi), .MOSI_OUT(mosi_o),
    .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso), .MISO_OUT(miso_o), .MISO_OE_OUT(miso_oe),
    .SEL_N_IN(seln), .SEL_N_OUT(sel_o), .SEL_OE_OUT(sel_oe));
  scc_slave_model i_scc_slave_model (.sel_n_in(seln), .mosi_in(mosi), .miso_out(part));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pslverr}, {31'h0, a > DATA_ADDR});
    if (!w) chk(prdata, {24'h0, e});
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wirq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask : wirq
  task automatic xfer(input logic [7:0] d);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'h20);
    bus(1'b1, DATA_ADDR, d, 8'h00);
    wirq(300);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'ha0);
  endtask : xfer
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // Hang guard, well beyond the thousand-odd cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, MAIN_CONTROL_ADDR, 8'h00, 8'h00);
    bus(1'b0, OPTION_CONTROL_ADDR, 8'h00, 8'h00);
    bus(1'b1, OPTION_CONTROL_ADDR, 8'hff, 8'h00);
    bus(1'b0, OPTION_CONTROL_ADDR, 8'h00, 8'h1b);
    bus(1'b1, 8'h10, 8'h5a, 8'h00);
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, MAIN_CONTROL_ADDR, tm[i], 8'h00);
      bus(1'b1, OPTION_CONTROL_ADDR, to[i], 8'h00);
      q = {27'h0, {sel_oe, mosi_oe, miso_oe, sck_oe, sck_o} & (i == 7 ? 5'h1a : 5'h1f)};
      chk(q, {27'h0, te[i]});
    end
    $display("pin functions done");
    bus(1'b1, OPTION_CONTROL_ADDR, 8'h10, 8'h00);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, MAIN_CONTROL_ADDR, 8'hd2 | {4'h0, m[2:1], 1'b0, m[0]}, 8'h00);
      xfer(8'h3c ^ 8'(m));
      bus(1'b0, DATA_ADDR, 8'h00, 8'h3c ^ 8'(m));
      chk({31'h0, irq}, 32'h0);
    end
    $display("master transfers done");
    bus(1'b1, MAIN_CONTROL_ADDR, 8'hd2, 8'h00);
    xfer(8'h81);
    bus(1'b1, DATA_ADDR, 8'h18, 8'h00);
    repeat (20) @(posedge clk);
    bus(1'b1, MAIN_CONTROL_ADDR, 8'h32, 8'h00);
    chk({30'h0, sck_oe, sel_oe}, 32'h0);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'h20);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, MAIN_CONTROL_ADDR, 8'h12, 8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("disable done");
    bus(1'b1, OPTION_CONTROL_ADDR, 8'h12, 8'h00);
    bus(1'b1, MAIN_CONTROL_ADDR, 8'hd2, 8'h00);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'h20);
    bus(1'b1, DATA_ADDR, 8'h66, 8'h00);
    wt <= 1'b1;
    repeat (100) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wt <= 1'b0;
    wirq(300);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'ha0);
    bus(1'b0, DATA_ADDR, 8'h00, 8'h66);
    $display("wait mode done");
    // Master with fault detect and no select drive: select low is a fault
    bus(1'b1, MAIN_CONTROL_ADDR, 8'hd0, 8'h00);
    tb_sel_n <= 1'b0;
    repeat (5) @(posedge clk);
    tb_sel_n <= 1'b1;
    repeat (5) @(posedge clk);
    wirq(20);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'h30);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'h20);
    chk({31'h0, irq}, 32'h0);
    $display("mode fault done");
    bus(1'b1, OPTION_CONTROL_ADDR, 8'h00, 8'h00);
    bus(1'b1, MAIN_CONTROL_ADDR, 8'hc0, 8'h00);
    tb_sel_n <= 1'b0;
    // Link clock of 48 ns, kept off the system clock edges
    #1.3;
    for (int b = 7; b >= 0; b--) begin
      tb_mosi <= SLV[b];
      #24 tb_sck <= 1'b1;
      #24 tb_sck <= 1'b0;
    end
    #24 tb_sel_n <= 1'b1;
    @(posedge clk);
    wirq(100);
    bus(1'b0, STATUS_ADDR, 8'h00, 8'ha0);
    bus(1'b0, DATA_ADDR, 8'h00, SLV);
    $display("slave link done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
